/* File: hw/psr_pkg.sv */
// Package: offsets, field positions and carriers for the peripheral reset block
package psr_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_GROUP_ONE = 12'h044;
  localparam logic [ADDR_W-1:0] OFS_GROUP_TWO = 12'h048;
  localparam logic [DATA_W-1:0] RESET_VALUE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // ************************************************************
  // Group one field positions
  // ************************************************************
  localparam int B1_SERIAL_ASYNC = 0;
  localparam int B1_SERIAL_SYNC = 4;
  localparam int B1_TWO_WIRE = 12;
  localparam int B1_COUNTER_A = 16;
  localparam int B1_COUNTER_B = 17;
  localparam int B1_COUNTER_C = 18;
  localparam int B1_COUNTER_D = 19;
  localparam int B1_COMP_A = 24;
  localparam int B1_COMP_B = 25;
  localparam logic [DATA_W-1:0] IMPL_MASK_ONE = 32'h030F_1011;

  // ************************************************************
  // Group two field positions
  // ************************************************************
  localparam int B2_PORT_A = 0;
  localparam int B2_PORT_B = 1;
  localparam int B2_PORT_C = 2;
  localparam int B2_PORT_D = 3;
  localparam int B2_PORT_E = 4;
  localparam int B2_DMA = 13;
  localparam int B2_USB = 16;
  localparam logic [DATA_W-1:0] IMPL_MASK_TWO = 32'h0001_201F;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } psr_req_s;

  typedef struct packed {
    logic comparator_b_reset;
    logic comparator_a_reset;
    logic gp_counter_d_reset;
    logic gp_counter_c_reset;
    logic gp_counter_b_reset;
    logic gp_counter_a_reset;
    logic two_wire_unit_reset;
    logic sync_serial_unit_reset;
    logic async_serial_port_reset;
    logic usb_unit_reset;
    logic dma_engine_reset;
    logic port_e_reset;
    logic port_d_reset;
    logic port_c_reset;
    logic port_b_reset;
    logic port_a_reset;
  } psr_resets_s;

endpackage

/* File: hw/psr_reg.sv */
// One masked software reset register with write gating
module psr_reg
  import psr_pkg::*;
#(
  parameter logic [DATA_W-1:0] IMPL_MASK = 32'h0000_0000
) (
  input wire logic clk,                      // System clock
  input wire logic resetn,                   // Async reset, active low
  input wire logic wr_en,                    // Write strobe for this register
  input wire logic [DATA_W-1:0] wdata,       // Write data
  input wire logic [DATA_W-1:0] cap_mask,    // Capability mask
  output logic [DATA_W-1:0] value            // Stored value
);

  logic [DATA_W-1:0] next_value;
  logic [DATA_W-1:0] wr_mask;

  // ************************************************************
  // Next value
  // ************************************************************
  always_comb begin
    wr_mask = cap_mask & IMPL_MASK;
    next_value = value;
    if (wr_en) begin
      next_value = (value & ~wr_mask) | (wdata & wr_mask);
    end
  end

  // ************************************************************
  // Storage
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end

  // Masked bits hold their value across a write
  a_masked_hold: assert property (@(posedge clk) disable iff (!resetn)
    wr_en |=> ((value & ~$past(wr_mask)) == ($past(value) & ~$past(wr_mask))))
    else $error("masked bit changed on write");

endmodule

/* File: hw/psr_out.sv */
// Registered reset line drive for one peripheral
module psr_out (
  input wire logic clk,     // System clock
  input wire logic resetn,  // Async reset, active low
  input wire logic ctl,     // Control bit
  output logic rst_out      // Peripheral reset, active high
);

  logic next_rst_out;

  always_comb begin
    next_rst_out = ctl;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_out <= 1'b0;
    end else begin
      rst_out <= next_rst_out;
    end
  end

endmodule

/* File: hw/psr_top.sv */
// Peripheral software reset control: two masked registers and reset lines
// Behaviour
// - Group one writes gated by capability two
// - Group two writes gated by capability four
// - Both registers 32-bit, reset to zero
// - Bits 19..16 reset counters d..a
// - Bits 25, 24 reset comparators b, a
// - Bits 12, 4, 0 reset serial units
// - Group two bits 4..0 reset ports e..a
// - Group two bits 16, 13 reset usb, dma
// - Unassigned bits read zero, ignore writes
module psr_top (
  input wire logic clk,                                // System clock, 10 MHz
  input wire logic resetn,                             // Async reset, active low
  input wire psr_pkg::psr_req_s req,                   // Register bus request
  input wire logic [psr_pkg::DATA_W-1:0] capability_mask_two,  // Presence mask, group one
  input wire logic [psr_pkg::DATA_W-1:0] capability_mask_four, // Presence mask, group two
  output logic [psr_pkg::DATA_W-1:0] rdata,            // Read data, cycle after read
  output psr_pkg::psr_resets_s resets                  // Peripheral resets, active high
);
  import psr_pkg::*;

  logic [DATA_W-1:0] group_one;
  logic [DATA_W-1:0] group_two;
  logic wr_one;
  logic wr_two;
  logic [DATA_W-1:0] next_rdata;
  logic [15:0] ctl_vec;
  logic [15:0] rst_vec;

  // ************************************************************
  // Address decode
  // ************************************************************
  always_comb begin
    wr_one = 1'b0;
    wr_two = 1'b0;
    if (req.wr && req.addr == OFS_GROUP_ONE) begin
      wr_one = 1'b1;
    end else if (req.wr && req.addr == OFS_GROUP_TWO) begin
      wr_two = 1'b1;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // gated group one
  psr_reg #(.IMPL_MASK(IMPL_MASK_ONE)) u_group_one (
    .clk(clk),
    .resetn(resetn),
    .wr_en(wr_one),
    .wdata(req.wdata),
    .cap_mask(capability_mask_two),
    .value(group_one)
  );

  psr_reg #(.IMPL_MASK(IMPL_MASK_TWO)) u_group_two (
    .clk(clk),
    .resetn(resetn),
    .wr_en(wr_two),
    .wdata(req.wdata),
    .cap_mask(capability_mask_four),
    .value(group_two)
  );

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    next_rdata = ZERO_WORD;
    if (req.rd && req.addr == OFS_GROUP_ONE) begin
      next_rdata = group_one & IMPL_MASK_ONE;
    end else if (req.rd && req.addr == OFS_GROUP_TWO) begin
      next_rdata = group_two & IMPL_MASK_TWO;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= ZERO_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ************************************************************
  // Reset line mapping
  // ************************************************************
  always_comb begin
    ctl_vec[15] = group_one[B1_COMP_B];
    ctl_vec[14] = group_one[B1_COMP_A];
    ctl_vec[13] = group_one[B1_COUNTER_D];
    ctl_vec[12] = group_one[B1_COUNTER_C];
    ctl_vec[11] = group_one[B1_COUNTER_B];
    ctl_vec[10] = group_one[B1_COUNTER_A];
    ctl_vec[9] = group_one[B1_TWO_WIRE];
    ctl_vec[8] = group_one[B1_SERIAL_SYNC];
    ctl_vec[7] = group_one[B1_SERIAL_ASYNC];
    ctl_vec[6] = group_two[B2_USB];
    ctl_vec[5] = group_two[B2_DMA];
    ctl_vec[4] = group_two[B2_PORT_E];
    ctl_vec[3] = group_two[B2_PORT_D];
    ctl_vec[2] = group_two[B2_PORT_C];
    ctl_vec[1] = group_two[B2_PORT_B];
    ctl_vec[0] = group_two[B2_PORT_A];
  end

  for (genvar i = 0; i < 16; i++) begin : g_out
    psr_out u_out (
      .clk(clk),
      .resetn(resetn),
      .ctl(ctl_vec[i]),
      .rst_out(rst_vec[i])
    );
  end

  always_comb begin
    resets = rst_vec;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_one_masked_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_one |=> (group_one == (($past(group_one) & ~($past(capability_mask_two) & IMPL_MASK_ONE))
      | ($past(req.wdata) & $past(capability_mask_two) & IMPL_MASK_ONE))))
    else $error("group one write not masked");

  a_two_masked_write: assert property (@(posedge clk) disable iff (!resetn)
    wr_two |=> (group_two == (($past(group_two) & ~($past(capability_mask_four) & IMPL_MASK_TWO))
      | ($past(req.wdata) & $past(capability_mask_four) & IMPL_MASK_TWO))))
    else $error("group two write not masked");

  a_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    ((group_one & ~IMPL_MASK_ONE) == ZERO_WORD) && ((group_two & ~IMPL_MASK_TWO) == ZERO_WORD))
    else $error("reserved bit set");

  a_read_one: assert property (@(posedge clk) disable iff (!resetn)
    (req.rd && req.addr == OFS_GROUP_ONE) |=> (rdata == $past(group_one)))
    else $error("group one read wrong");

  a_read_two: assert property (@(posedge clk) disable iff (!resetn)
    (req.rd && req.addr == OFS_GROUP_TWO) |=> (rdata == $past(group_two)))
    else $error("group two read wrong");

  a_counter_map: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (resets.gp_counter_d_reset == $past(group_one[B1_COUNTER_D]))
    && (resets.gp_counter_a_reset == $past(group_one[B1_COUNTER_A])))
    else $error("counter reset mapping wrong");

  a_comp_map: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (resets.comparator_b_reset == $past(group_one[B1_COMP_B]))
    && (resets.comparator_a_reset == $past(group_one[B1_COMP_A])))
    else $error("comparator reset mapping wrong");

  a_serial_map: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (resets.two_wire_unit_reset == $past(group_one[B1_TWO_WIRE]))
    && (resets.sync_serial_unit_reset == $past(group_one[B1_SERIAL_SYNC]))
    && (resets.async_serial_port_reset == $past(group_one[B1_SERIAL_ASYNC])))
    else $error("serial reset mapping wrong");

  a_port_map: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (resets.port_e_reset == $past(group_two[B2_PORT_E]))
    && (resets.port_a_reset == $past(group_two[B2_PORT_A])))
    else $error("port reset mapping wrong");

  a_usb_dma_map: assert property (@(posedge clk) disable iff (!resetn)
    ##1 (resets.usb_unit_reset == $past(group_two[B2_USB]))
    && (resets.dma_engine_reset == $past(group_two[B2_DMA])))
    else $error("usb or dma reset mapping wrong");

  a_held_reset: assert property (@(posedge clk) disable iff (!resetn)
    (group_two[B2_USB] && $past(group_two[B2_USB])) |-> resets.usb_unit_reset)
    else $error("peripheral released while bit set");

endmodule

/* File: verif/test_psr_top.sv */
// Self-checking bench for the peripheral software reset control block
module test_psr_top;
  timeunit 1ns;
  timeprecision 1ns;
  import psr_pkg::*;

  // ************************************************************
  // Stimulus and observation signals
  // ************************************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  psr_req_s req = '0;
  logic [DATA_W-1:0] cap_two = 32'hffff_ffff;
  logic [DATA_W-1:0] cap_four = 32'hffff_ffff;
  logic [DATA_W-1:0] rdata;
  psr_resets_s resets;
  logic [DATA_W-1:0] got;
  logic [DATA_W-1:0] m1 = 32'h0000_0000;
  logic [DATA_W-1:0] m2 = 32'h0000_0000;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  psr_top dut (
    .clk(clk),
    .resetn(resetn),
    .req(req),
    .capability_mask_two(cap_two),
    .capability_mask_four(cap_four),
    .rdata(rdata),
    .resets(resets)
  );

  // ************************************************************
  // Closing report and hang guard
  // ************************************************************
  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      $display("unexpected at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  // ************************************************************
  // Bus tasks and comparison
  // ************************************************************
  task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #10;
    d = rdata;
  endtask

  // Write and track expected contents, gated by presence and implemented bits
  task automatic wx(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] k1;
    logic [DATA_W-1:0] k2;
    k1 = IMPL_MASK_ONE & cap_two;
    k2 = IMPL_MASK_TWO & cap_four;
    wr(a, d);
    if (a == OFS_GROUP_ONE)
      m1 = (m1 & ~k1) | (d & k1);
    if (a == OFS_GROUP_TWO)
      m2 = (m2 & ~k2) | (d & k2);
  endtask

  function automatic psr_resets_s exp_res(input logic [DATA_W-1:0] g1, input logic [DATA_W-1:0] g2);
    return {g1[25], g1[24], g1[19:16], g1[12], g1[4], g1[0], g2[16], g2[13], g2[4:0]};
  endfunction

  task automatic check_all;
    rd(OFS_GROUP_ONE, got);
    chk(got, m1, "group one");
    rd(OFS_GROUP_TWO, got);
    chk(got, m2, "group two");
    chk({16'h0000, resets}, {16'h0000, exp_res(m1, m2)}, "reset lines");
  endtask

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    check_all();
    wx(OFS_GROUP_ONE, 32'hffff_ffff);
    wx(OFS_GROUP_TWO, 32'hffff_ffff);
    check_all();
    for (int i = 0; i < 32; i++) begin
      wx(OFS_GROUP_ONE, 32'h0000_0001 << i);
      wx(OFS_GROUP_TWO, 32'h0000_0001 << i);
      check_all();
    end
    wx(OFS_GROUP_ONE, 32'hffff_ffff);
    wx(OFS_GROUP_TWO, 32'hffff_ffff);
    @(posedge clk);
    cap_two <= 32'h0100_0001;
    cap_four <= 32'h0000_2001;
    @(posedge clk);
    wx(OFS_GROUP_ONE, 32'h0000_0000);
    wx(OFS_GROUP_TWO, 32'h0000_0000);
    check_all();
    // Masks change only at a rising edge
    @(posedge clk);
    cap_two <= 32'hfcf0_efee;
    cap_four <= 32'hfffe_dffe;
    @(posedge clk);
    wx(OFS_GROUP_ONE, 32'h0000_0000);
    wx(OFS_GROUP_TWO, 32'h0000_0000);
    check_all();
    @(posedge clk);
    cap_two <= 32'hffff_ffff;
    cap_four <= 32'hffff_ffff;
    // Let the new masks settle before the model reads them
    @(posedge clk);
    wx(OFS_GROUP_ONE, 32'h0000_1010);
    wr(12'h04c, 32'hffff_ffff);
    wr(12'h040, 32'hffff_ffff);
    check_all();
    rd(12'h04c, got);
    chk(got, 32'h0000_0000, "unmapped read");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    m1 = 32'h0000_0000;
    m2 = 32'h0000_0000;
    check_all();
    end_of_test();
  end
endmodule
